/* File: hdl/capture_pkg.sv */
package capture_pkg;

    // pixel word and fifo word layout
    localparam int PIX_W = 8;
    localparam int SOL_BIT = PIX_W;
    localparam int SOF_BIT = PIX_W + 1;
    localparam int WORD_W = PIX_W + 2;
    localparam int FIFO_DEPTH = 8;

    // timing mode codes on the mode select input
    localparam logic [1:0] MODE_EMBEDDED = 2'h0;
    localparam logic [1:0] MODE_GATED = 2'h1;
    localparam logic [1:0] MODE_NONGATED = 2'h2;
    localparam logic [1:0] MODE_RESET = 2'h1;

    // embedded timing code preamble and status word bits
    localparam logic [PIX_W-1:0] CODE_PRE_HI = 8'hff;
    localparam logic [PIX_W-1:0] CODE_PRE_LO = 8'h00;
    localparam int XY_V_BIT = 5;
    localparam int XY_H_BIT = 4;

    // synchroniser width for the regenerated frame and line levels
    localparam int LVL_W = 2;

    // reset values
    localparam logic [PIX_W-1:0] PIX_RESET = 8'h00;
    localparam logic [WORD_W-1:0] WORD_RESET = 10'h000;

endpackage

/* File: hdl/sync_stage.sv */
module sync_stage
    import capture_pkg::*;
#(
    parameter int W = 1
)
(
    // destination clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // level from the other domain
    input wire logic [W-1:0] i_async,
    // level in this domain
    output logic [W-1:0] o_sync
);

    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    // first flop feeds only the second
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;

endmodule

/* File: hdl/async_fifo.sv */
module async_fifo
    import capture_pkg::*;
#(
    parameter int W = WORD_W,
    parameter int DEPTH = FIFO_DEPTH
)
(
    // write side, link clock
    input wire logic i_wr_clk,
    input wire logic i_wr_rstn,
    input wire logic i_wr_valid,
    input wire logic [W-1:0] i_wr_data,
    output logic o_wr_ready,
    // read side, system clock
    input wire logic i_rd_clk,
    input wire logic i_rd_rstn,
    output logic o_rd_valid,
    output logic [W-1:0] o_rd_data,
    input wire logic i_rd_ready
);

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wbin_r;
    logic [AW:0] wgray_r;
    logic [AW:0] rbin_r;
    logic [AW:0] rgray_r;
    logic [AW:0] wgray_rd;
    logic [AW:0] rgray_wr;
    logic [AW:0] wbin_nxt;
    logic [AW:0] rbin_nxt;
    logic do_wr;
    logic do_rd;

    // full when the write pointer is one lap ahead of the read pointer
    assign o_wr_ready = wgray_r != {~rgray_wr[AW:AW-1], rgray_wr[AW-2:0]};
    assign o_rd_valid = rgray_r != wgray_rd;
    assign do_wr = i_wr_valid && o_wr_ready;
    assign do_rd = o_rd_valid && i_rd_ready;
    assign wbin_nxt = wbin_r + (AW+1)'(1);
    assign rbin_nxt = rbin_r + (AW+1)'(1);
    assign o_rd_data = mem[rbin_r[AW-1:0]];

    always_ff @(posedge i_wr_clk)
    begin
        if (do_wr)
        begin
            mem[wbin_r[AW-1:0]] <= i_wr_data;
        end
    end

    always_ff @(posedge i_wr_clk or negedge i_wr_rstn)
    begin
        if (!i_wr_rstn)
        begin
            wbin_r <= '0;
            wgray_r <= '0;
        end
        else if (do_wr)
        begin
            wbin_r <= wbin_nxt;
            wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
        end
    end

    always_ff @(posedge i_rd_clk or negedge i_rd_rstn)
    begin
        if (!i_rd_rstn)
        begin
            rbin_r <= '0;
            rgray_r <= '0;
        end
        else if (do_rd)
        begin
            rbin_r <= rbin_nxt;
            rgray_r <= rbin_nxt ^ (rbin_nxt >> 1);
        end
    end

    // gray pointers cross through two flops each
    sync_stage #(.W(AW+1)) u_wptr_sync (
        .i_clk(i_rd_clk),
        .i_rstn(i_rd_rstn),
        .i_async(wgray_r),
        .o_sync(wgray_rd)
    );

    sync_stage #(.W(AW+1)) u_rptr_sync (
        .i_clk(i_wr_clk),
        .i_rstn(i_wr_rstn),
        .i_async(rgray_r),
        .o_sync(rgray_wr)
    );

endmodule

/* File: hdl/camera_capture_port.sv */
// What this block and the sensor do
// [RL1] embedded mode: only pixel clock, timing in data
// [RL2] sensor frames each active line with start/end codes
// [RL3] blanking words between end and start dropped
// [RL4] codes decoded, removed, frame/line sync regenerated
// [RL5] gated mode uses frame, line sync and clock
// [RL6] rising frame sync starts each new frame
// [RL7] sensor holds line sync high whole line
// [RL8] gated: pixels latched only while line sync high
// [RL9] line sync low: pixels ignored until rise
// [RL10] non-gated: line sync ignored, every clock stored
// [RL11] sensor clock idles low outside valid data
// [RL12] selectable mode, exactly one applied at once
module camera_capture_port
    import capture_pkg::*;
(
    // system clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // mode select and overflow clear
    input wire logic [1:0] i_mode,
    input wire logic i_overflow_clear,
    // sensor pins
    input wire logic i_sensor_pixel_clock,
    input wire logic i_sensor_frame_sync,
    input wire logic i_sensor_line_sync,
    input wire logic [PIX_W-1:0] i_sensor_data,
    // captured pixel stream
    output logic o_pix_valid,
    output logic [PIX_W-1:0] o_pix_data,
    output logic o_pix_sof,
    output logic o_pix_sol,
    input wire logic i_pix_ready,
    // regenerated timing and status
    output logic o_frame_sync,
    output logic o_line_sync,
    output logic o_overflow,
    output logic [1:0] o_mode
);

    // system domain
    logic [1:0] mode_r;
    logic out_valid_r;
    logic [WORD_W-1:0] out_word_r;
    logic [LVL_W-1:0] lvl_sys;
    logic [LVL_W-1:0] lvl_r;
    logic ovf_req_sys;
    logic ovf_req_q;
    logic ovf_r;
    logic fifo_rd_valid;
    logic [WORD_W-1:0] fifo_rd_data;
    logic fifo_rd_ready;

    // link domain
    logic [1:0] link_rst_r;
    logic link_rstn;
    logic [1:0] mode_sync;
    logic [1:0] mode_q;
    logic [1:0] mode_l;
    logic [PIX_W-1:0] d_r;
    logic fs_r;
    logic fs_q;
    logic ls_r;
    logic ls_q;
    logic [PIX_W-1:0] d1_r;
    logic [PIX_W-1:0] d2_r;
    logic [PIX_W-1:0] d3_r;
    logic v1_r;
    logic v2_r;
    logic v3_r;
    logic emb_line_r;
    logic emb_frame_r;
    logic sof_pend_r;
    logic sol_pend_r;
    logic wr_valid_r;
    logic [WORD_W-1:0] wr_word_r;
    logic wr_ready;
    logic ovf_req_r;
    logic ovf_ack_link;
    logic [LVL_W-1:0] lvl_link_r;
    logic code_det;
    logic sav_act;
    logic eav_det;
    logic fs_rise;
    logic ls_rise;
    logic cand;
    logic [PIX_W-1:0] cand_data;
    logic sof_set;
    logic sol_set;

    function automatic logic mode_legal(input logic [1:0] m);
        mode_legal = (m == MODE_EMBEDDED) || (m == MODE_GATED) || (m == MODE_NONGATED);
    endfunction

    // mode register keeps its last legal code
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            mode_r <= MODE_RESET;
        end
        else if (mode_legal(i_mode))
        begin
            mode_r <= i_mode; // [RL12]
        end
    end

    // link reset: asserted at once, released on the pixel clock
    always_ff @(posedge i_sensor_pixel_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            link_rst_r <= 2'h0;
        end
        else
        begin
            link_rst_r <= {link_rst_r[0], 1'b1};
        end
    end

    assign link_rstn = link_rst_r[1];

    sync_stage #(.W(2)) u_mode_sync (
        .i_clk(i_sensor_pixel_clock),
        .i_rstn(link_rstn),
        .i_async(mode_r),
        .o_sync(mode_sync)
    );

    // mode is taken only once two samples agree
    always_ff @(posedge i_sensor_pixel_clock or negedge link_rstn)
    begin
        if (!link_rstn)
        begin
            mode_q <= MODE_RESET;
            mode_l <= MODE_RESET;
        end
        else
        begin
            mode_q <= mode_sync;
            if (mode_q == mode_sync && mode_legal(mode_sync))
            begin
                mode_l <= mode_sync; // [RL12]
            end
        end
    end

    // pins are launched on the pixel clock, so one sampling flop
    always_ff @(posedge i_sensor_pixel_clock or negedge link_rstn)
    begin
        if (!link_rstn)
        begin
            d_r <= PIX_RESET;
            fs_r <= 1'b0;
            fs_q <= 1'b0;
            ls_r <= 1'b0;
            ls_q <= 1'b0;
        end
        else
        begin
            d_r <= i_sensor_data; // [RL8]
            fs_r <= i_sensor_frame_sync;
            fs_q <= fs_r;
            ls_r <= i_sensor_line_sync;
            ls_q <= ls_r;
        end
    end

    // embedded codes: preamble sits in d3..d1, status word in d_r
    assign code_det = (mode_l == MODE_EMBEDDED) && (d3_r == CODE_PRE_HI)
        && (d2_r == CODE_PRE_LO) && (d1_r == CODE_PRE_LO); // [RL1]
    assign sav_act = code_det && !d_r[XY_H_BIT] && !d_r[XY_V_BIT];
    assign eav_det = code_det && d_r[XY_H_BIT];
    assign fs_rise = fs_r && !fs_q;
    assign ls_rise = ls_r && !ls_q;

    // delay line holds words until they are known not to be codes
    always_ff @(posedge i_sensor_pixel_clock or negedge link_rstn)
    begin
        if (!link_rstn)
        begin
            d1_r <= PIX_RESET;
            d2_r <= PIX_RESET;
            d3_r <= PIX_RESET;
            v1_r <= 1'b0;
            v2_r <= 1'b0;
            v3_r <= 1'b0;
        end
        else
        begin
            d1_r <= d_r;
            d2_r <= d1_r;
            d3_r <= d2_r;
            if (code_det)
            begin
                v1_r <= 1'b0; // [RL4]
                v2_r <= 1'b0;
                v3_r <= 1'b0;
            end
            else
            begin
                v1_r <= emb_line_r; // [RL3]
                v2_r <= v1_r;
                v3_r <= v2_r;
            end
        end
    end

    // regenerated line and frame levels in embedded mode
    always_ff @(posedge i_sensor_pixel_clock or negedge link_rstn)
    begin
        if (!link_rstn)
        begin
            emb_line_r <= 1'b0;
            emb_frame_r <= 1'b0;
        end
        else if (mode_l != MODE_EMBEDDED)
        begin
            emb_line_r <= 1'b0;
            emb_frame_r <= 1'b0;
        end
        else if (code_det)
        begin
            emb_line_r <= sav_act; // [RL4]
            emb_frame_r <= !d_r[XY_V_BIT]; // [RL4]
        end
    end

    // pixel candidate per mode
    always_comb
    begin
        cand = 1'b0;
        cand_data = d_r;
        sof_set = 1'b0;
        sol_set = 1'b0;
        case (mode_l)
            MODE_EMBEDDED:
            begin
                cand = v3_r && !code_det; // [RL3]
                cand_data = d3_r;
                sof_set = sav_act && !emb_frame_r;
                sol_set = sav_act;
            end
            MODE_GATED:
            begin
                cand = ls_r; // [RL8] [RL9]
                sof_set = fs_rise; // [RL6]
                sol_set = ls_rise; // [RL5]
            end
            MODE_NONGATED:
            begin
                cand = 1'b1; // [RL10]
                sof_set = fs_rise; // [RL6]
            end
            default:
            begin
                cand = 1'b0;
            end
        endcase
    end

    // start markers wait for the next stored pixel; a pixel stored with its
    // own start takes the marker at once, a mode change drops stale markers
    always_ff @(posedge i_sensor_pixel_clock or negedge link_rstn)
    begin
        if (!link_rstn)
        begin
            sof_pend_r <= 1'b0;
            sol_pend_r <= 1'b0;
        end
        else
        begin
            if (cand || mode_q != mode_l)
            begin
                sof_pend_r <= 1'b0;
            end
            else if (sof_set)
            begin
                sof_pend_r <= 1'b1; // [RL6]
            end
            if (cand || mode_q != mode_l)
            begin
                sol_pend_r <= 1'b0;
            end
            else if (sol_set)
            begin
                sol_pend_r <= 1'b1;
            end
        end
    end

    // write stage; a word meeting a full fifo is dropped and flagged
    always_ff @(posedge i_sensor_pixel_clock or negedge link_rstn)
    begin
        if (!link_rstn)
        begin
            wr_valid_r <= 1'b0;
            wr_word_r <= WORD_RESET;
            ovf_req_r <= 1'b0;
            lvl_link_r <= '0;
        end
        else
        begin
            wr_valid_r <= cand;
            wr_word_r <= {sof_pend_r || sof_set, sol_pend_r || sol_set, cand_data}; // [RL6]
            // drop request held until acknowledged: pixel clock outruns sys clock
            if (wr_valid_r && !wr_ready)
            begin
                ovf_req_r <= 1'b1;
            end
            else if (ovf_ack_link)
            begin
                ovf_req_r <= 1'b0;
            end
            if (mode_l == MODE_EMBEDDED)
            begin
                lvl_link_r <= {emb_frame_r, emb_line_r}; // [RL4]
            end
            else
            begin
                lvl_link_r <= {fs_r, ls_r && (mode_l == MODE_GATED)}; // [RL5]
            end
        end
    end

    async_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_wr_clk(i_sensor_pixel_clock),
        .i_wr_rstn(link_rstn),
        .i_wr_valid(wr_valid_r),
        .i_wr_data(wr_word_r),
        .o_wr_ready(wr_ready),
        .i_rd_clk(i_clk_sys),
        .i_rd_rstn(i_resetn),
        .o_rd_valid(fifo_rd_valid),
        .o_rd_data(fifo_rd_data),
        .i_rd_ready(fifo_rd_ready)
    );

    sync_stage #(.W(LVL_W)) u_lvl_sync (
        .i_clk(i_clk_sys),
        .i_rstn(i_resetn),
        .i_async(lvl_link_r),
        .o_sync(lvl_sys)
    );

    sync_stage #(.W(1)) u_ovf_sync (
        .i_clk(i_clk_sys),
        .i_rstn(i_resetn),
        .i_async(ovf_req_r),
        .o_sync(ovf_req_sys)
    );

    sync_stage #(.W(1)) u_ovf_ack_sync (
        .i_clk(i_sensor_pixel_clock),
        .i_rstn(link_rstn),
        .i_async(ovf_req_q),
        .o_sync(ovf_ack_link)
    );

    // output register drains the fifo
    assign fifo_rd_ready = !out_valid_r || i_pix_ready;

    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            out_valid_r <= 1'b0;
            out_word_r <= WORD_RESET;
        end
        else if (fifo_rd_ready)
        begin
            out_valid_r <= fifo_rd_valid;
            out_word_r <= fifo_rd_data;
        end
    end

    // status: levels and sticky overflow, set beats clear
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            lvl_r <= '0;
            ovf_req_q <= 1'b0;
            ovf_r <= 1'b0;
        end
        else
        begin
            lvl_r <= lvl_sys;
            ovf_req_q <= ovf_req_sys;
            if (ovf_req_sys && !ovf_req_q)
            begin
                ovf_r <= 1'b1;
            end
            else if (i_overflow_clear)
            begin
                ovf_r <= 1'b0;
            end
        end
    end

    assign o_pix_valid = out_valid_r;
    assign o_pix_data = out_word_r[PIX_W-1:0];
    assign o_pix_sof = out_word_r[SOF_BIT];
    assign o_pix_sol = out_word_r[SOL_BIT];
    assign o_frame_sync = lvl_r[1];
    assign o_line_sync = lvl_r[0];
    assign o_overflow = ovf_r;
    assign o_mode = mode_r;

    // link domain checks
    AST_GATED_NO_LINE: assert property ( // [RL9]
        @(posedge i_sensor_pixel_clock) disable iff (!link_rstn)
        (mode_l == MODE_GATED && !ls_r) |=> !wr_valid_r)
        else $error("pixel stored while line sync low");

    AST_GATED_LATCH: assert property ( // [RL8]
        @(posedge i_sensor_pixel_clock) disable iff (!link_rstn)
        (mode_l == MODE_GATED && ls_r)
        |=> wr_valid_r && wr_word_r[PIX_W-1:0] == $past(d_r))
        else $error("gated pixel not latched");

    AST_NONGATED_ALL: assert property ( // [RL10]
        @(posedge i_sensor_pixel_clock) disable iff (!link_rstn)
        (mode_l == MODE_NONGATED) |=> wr_valid_r && !wr_word_r[SOL_BIT])
        else $error("non-gated clock did not store");

    AST_FRAME_RISE: assert property ( // [RL6]
        @(posedge i_sensor_pixel_clock) disable iff (!link_rstn)
        (mode_l != MODE_EMBEDDED && fs_r && !fs_q)
        |=> sof_pend_r || (wr_valid_r && wr_word_r[SOF_BIT]))
        else $error("frame start not marked");

    AST_EAV_BLANK: assert property ( // [RL3]
        @(posedge i_sensor_pixel_clock) disable iff (!link_rstn)
        eav_det |-> !cand ##1 !wr_valid_r [*3])
        else $error("code or blanking stored after end code");

    AST_SAV_LINE: assert property ( // [RL4]
        @(posedge i_sensor_pixel_clock) disable iff (!link_rstn)
        sav_act |=> emb_line_r && !v1_r ##1 v1_r)
        else $error("line not opened after start code");

    AST_EAV_LINE: assert property ( // [RL4]
        @(posedge i_sensor_pixel_clock) disable iff (!link_rstn)
        eav_det |=> !emb_line_r && !v1_r && !v2_r && !v3_r)
        else $error("line not closed after end code");

    // system domain checks
    AST_MODE_ONE: assert property ( // [RL12]
        @(posedge i_clk_sys) disable iff (!i_resetn)
        !mode_legal(i_mode) |=> $stable(mode_r) && mode_legal(mode_r))
        else $error("illegal mode applied");

    AST_OUT_HOLD: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (out_valid_r && !i_pix_ready) |=> out_valid_r && $stable(out_word_r))
        else $error("pixel output changed while stalled");

    AST_OVF_STICKY: assert property (
        @(posedge i_clk_sys) disable iff (!i_resetn)
        (ovf_r && !i_overflow_clear) |=> ovf_r)
        else $error("overflow flag lost");

endmodule

/* File: testbench/sensor_model.sv */
module sensor_model
    import capture_pkg::*;
(
    // sensor pins
    output logic o_pixel_clock,
    output logic o_frame_sync,
    output logic o_line_sync,
    output logic [PIX_W-1:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;

    // clock rests low between bursts
    initial
    begin
        o_pixel_clock = 1'b0;
        o_frame_sync = 1'b0;
        o_line_sync = 1'b0;
        o_data = PIX_RESET;
    end

    // one pixel clock: pins set while clock low, sampled on the rise
    task automatic word(input logic fs, input logic ls, input logic [PIX_W-1:0] d);
        o_frame_sync = fs;
        o_line_sync = ls;
        o_data = d;
        #24 o_pixel_clock = 1'b1;
        #24 o_pixel_clock = 1'b0;
    endtask

    // filler clocks, data inverted each time so a stale value never passes
    task automatic idle(input logic fs, input logic ls, input int n);
        repeat (n) word(fs, ls, ~o_data);
    endtask
endmodule

/* File: testbench/camera_capture_port_bench.sv */
module camera_capture_port_bench;
    import capture_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_clk_sys, i_resetn, i_overflow_clear, i_pix_ready;
    logic [1:0] i_mode;
    logic pclk, fs, ls;
    logic [PIX_W-1:0] sdata;
    logic o_pix_valid, o_pix_sof, o_pix_sol, o_frame_sync, o_line_sync, o_overflow;
    logic [PIX_W-1:0] o_pix_data;
    logic [1:0] o_mode;
    logic [WORD_W-1:0] got_q[$];
    logic [WORD_W-1:0] exp_q[$];
    int err_total = 0;
    int samples_checked = 0;

    camera_capture_port uut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_mode(i_mode),
        .i_overflow_clear(i_overflow_clear), .i_sensor_pixel_clock(pclk),
        .i_sensor_frame_sync(fs), .i_sensor_line_sync(ls), .i_sensor_data(sdata),
        .o_pix_valid(o_pix_valid), .o_pix_data(o_pix_data), .o_pix_sof(o_pix_sof),
        .o_pix_sol(o_pix_sol), .i_pix_ready(i_pix_ready), .o_frame_sync(o_frame_sync),
        .o_line_sync(o_line_sync), .o_overflow(o_overflow), .o_mode(o_mode));

    sensor_model sensor (.o_pixel_clock(pclk), .o_frame_sync(fs), .o_line_sync(ls),
        .o_data(sdata));

    initial
    begin
        i_clk_sys = 1'b0;
        forever #50 i_clk_sys = ~i_clk_sys;
    end

    // consumer collects every accepted word
    always @(posedge i_clk_sys)
    begin
        if (o_pix_valid === 1'b1 && i_pix_ready === 1'b1)
        begin
            got_q.push_back({o_pix_sof, o_pix_sol, o_pix_data});
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict;
        $display("mismatches %0d, comparisons %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic expect_word(input logic sof, input logic sol, input logic [PIX_W-1:0] d);
        exp_q.push_back({sof, sol, d});
    endtask

    // waits for the expected words, then compares them in order
    task automatic check_words(input bit exact);
        int n;
        n = exp_q.size();
        for (int t = 0; t < 300 && got_q.size() < n; t++)
            @(negedge i_clk_sys);
        repeat (20) @(negedge i_clk_sys);
        if (exact)
            chk("word count", 16'(n), 16'(got_q.size()));
        else
            chk("enough words", 16'h1, 16'(got_q.size() >= n));
        foreach (exp_q[i])
            if (i < got_q.size())
                chk("pixel word", 16'(exp_q[i]), 16'(got_q[i]));
        exp_q.delete();
        got_q.delete();
    endtask

    // new mode, link given time to follow, leftovers flushed
    task automatic set_mode(input logic [1:0] m);
        @(negedge i_clk_sys);
        i_mode = m;
        repeat (3) @(negedge i_clk_sys);
        chk("mode", 16'(m), 16'(o_mode));
        sensor.idle(1'b0, 1'b0, 8);
        repeat (20) @(negedge i_clk_sys);
        got_q.delete();
    endtask

    task automatic send_code(input logic [PIX_W-1:0] xy);
        sensor.word(1'b0, 1'b0, CODE_PRE_HI);
        sensor.word(1'b0, 1'b0, CODE_PRE_LO);
        sensor.word(1'b0, 1'b0, CODE_PRE_LO);
        sensor.word(1'b0, 1'b0, xy);
    endtask

    task automatic test_modes;
        logic [1:0] codes[3] = '{MODE_EMBEDDED, MODE_GATED, MODE_NONGATED};
        foreach (codes[i])
            set_mode(codes[i]);
        @(negedge i_clk_sys);
        i_mode = 2'h3;
        repeat (3) @(negedge i_clk_sys);
        chk("mode after code 3", 16'(MODE_NONGATED), 16'(o_mode));
    endtask

    task automatic test_gated;
        set_mode(MODE_GATED);
        sensor.word(1'b1, 1'b0, 8'h11);
        for (int i = 0; i < 3; i++)
        begin
            sensor.word(1'b1, 1'b1, 8'h20 + 8'(i));
            expect_word(i == 0, i == 0, 8'h20 + 8'(i));
        end
        sensor.word(1'b1, 1'b0, 8'h55);
        sensor.word(1'b1, 1'b0, 8'h56);
        for (int i = 0; i < 2; i++)
        begin
            sensor.word(1'b1, 1'b1, 8'h30 + 8'(i));
            expect_word(1'b0, i == 0, 8'h30 + 8'(i));
        end
        sensor.idle(1'b1, 1'b0, 6);
        check_words(1'b1);
        chk("frame level", 16'h1, 16'(o_frame_sync));
        chk("line level", 16'h0, 16'(o_line_sync));
        sensor.idle(1'b0, 1'b0, 2);
        sensor.word(1'b1, 1'b1, 8'h40);
        expect_word(1'b1, 1'b1, 8'h40);
        sensor.idle(1'b1, 1'b0, 6);
        check_words(1'b1);
    endtask

    task automatic test_nongated;
        set_mode(MODE_NONGATED);
        // last two filler words were still in the pipe when set_mode flushed the leftovers
        expect_word(1'b0, 1'b0, ~sdata);
        expect_word(1'b0, 1'b0, sdata);
        for (int i = 0; i < 6; i++)
        begin
            sensor.word(1'b1, 1'(i), 8'h60 + 8'(i));
            if (i < 4)
                expect_word(i == 0, 1'b0, 8'h60 + 8'(i));
        end
        check_words(1'b1);
        chk("line level", 16'h0, 16'(o_line_sync));
    endtask

    task automatic test_embedded;
        set_mode(MODE_EMBEDDED);
        send_code(8'hb0);
        sensor.word(1'b0, 1'b0, 8'h80);
        sensor.word(1'b0, 1'b0, 8'h10);
        sensor.idle(1'b0, 1'b0, 12);
        chk("frame level in blanking", 16'h0, 16'(o_frame_sync));
        send_code(8'ha0);
        sensor.word(1'b0, 1'b0, 8'h77);
        send_code(8'hb0);
        send_code(8'h80);
        for (int i = 0; i < 3; i++)
        begin
            sensor.word(1'b0, 1'b0, 8'h21 + 8'(i));
            expect_word(i == 0, i == 0, 8'h21 + 8'(i));
        end
        send_code(8'h90);
        sensor.word(1'b0, 1'b0, 8'h10);
        sensor.word(1'b0, 1'b0, 8'h80);
        send_code(8'h80);
        for (int i = 0; i < 2; i++)
        begin
            sensor.word(1'b0, 1'b0, 8'h31 + 8'(i));
            expect_word(1'b0, i == 0, 8'h31 + 8'(i));
        end
        send_code(8'h90);
        sensor.idle(1'b0, 1'b0, 12);
        check_words(1'b1);
        chk("frame level active", 16'h1, 16'(o_frame_sync));
        chk("line level after end code", 16'h0, 16'(o_line_sync));
    endtask

    task automatic test_overflow;
        set_mode(MODE_GATED);
        i_pix_ready = 1'b0;
        sensor.idle(1'b0, 1'b0, 2);
        for (int i = 0; i < 12; i++)
            sensor.word(1'b1, 1'b1, 8'h40 + 8'(i));
        sensor.idle(1'b1, 1'b0, 6);
        repeat (15) @(negedge i_clk_sys);
        chk("overflow", 16'h1, 16'(o_overflow));
        chk("stalled valid", 16'h1, 16'(o_pix_valid));
        i_pix_ready = 1'b1;
        for (int i = 0; i < 8; i++)
            expect_word(i == 0, i == 0, 8'h40 + 8'(i));
        repeat (30) @(negedge i_clk_sys);
        chk("drained at most", 16'h1, 16'(got_q.size() <= 10));
        check_words(1'b0);
        chk("overflow sticky", 16'h1, 16'(o_overflow));
        i_overflow_clear = 1'b1;
        @(negedge i_clk_sys);
        i_overflow_clear = 1'b0;
        repeat (2) @(negedge i_clk_sys);
        chk("overflow cleared", 16'h0, 16'(o_overflow));
    endtask

    initial
    begin
        #2000000;
        err_total++;
        give_verdict();
    end

    initial
    begin
        i_resetn = 1'b0;
        i_mode = MODE_GATED;
        i_overflow_clear = 1'b0;
        i_pix_ready = 1'b1;
        fork
            repeat (16) @(negedge i_clk_sys);
            sensor.idle(1'b0, 1'b0, 10);
        join
        chk("reset mode", 16'(MODE_RESET), 16'(o_mode));
        chk("reset valid", 16'h0, 16'(o_pix_valid));
        chk("reset overflow", 16'h0, 16'(o_overflow));
        chk("reset frame level", 16'h0, 16'(o_frame_sync));
        i_resetn = 1'b1;
        sensor.idle(1'b0, 1'b0, 6);
        test_modes();
        test_gated();
        test_nongated();
        test_embedded();
        test_overflow();
        give_verdict();
    end
endmodule
